// [tb/epi_detect_bench.sv]
// self-checking bench for the external pin interrupt detect block
`timescale 1ns/10ps
module epi_detect_bench;
   import epi_pkg::*;
   logic mclk = 0, resetn = 0, hsel = 0, hwrite = 0, drv_val = 1, drv_en = 1, irq_pin;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, pull_up_en, pull_down_en, cpu_irq, sys_irq;
   int err_total = 0, tests_run = 0;
   always #20 mclk = ~mclk;
   epi_detect i_dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq_pin(irq_pin), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .cpu_irq(cpu_irq), .sys_irq(sys_irq));
   epi_pin_src i_pin (.mclk(mclk), .drive_en(drv_en), .drive_val(drv_val),
      .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .irq_pin(irq_pin));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         err_total++;
         finish_test();
      end
   endtask : wait_rdy
   // one single word transfer; read data taken at the data phase edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      #1;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      bus(1'b1, a, {24'h0, d}, rd);
   endtask : wr
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      chk(name, {24'h0, exp}, rd);
   endtask : rd_chk
   // pin moves, then four edges pass, covering the sync and flag edges
   task automatic pin_go(input logic v);
      @(posedge mclk);
      drv_val <= v;
      repeat (4) @(posedge mclk);
      #1;
   endtask : pin_go
   // hand the pin over to the pull resistor, or take it back
   task automatic pin_rel(input logic en);
      @(posedge mclk);
      drv_en <= en;
      repeat (4) @(posedge mclk);
      #1;
   endtask : pin_rel
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      rd_chk("ctrl", EPI_ADDR_CTRL, EPI_CTRL_RST);
      rd_chk("evt", EPI_ADDR_EVT, 8'h00);
      rd_chk("mask", EPI_ADDR_MASK, 8'h00);
      rd_chk("unmapped", 8'h10, 8'h00);
      chk("irqs", 2'h0, {cpu_irq, sys_irq});
      chk("bus resp", 2'h2, {hreadyout, hresp});
   endtask : t_reset
   // pin function off: activity never raises the flag
   task automatic t_disabled();
      wr(EPI_ADDR_CTRL, 8'h02);
      pin_go(1'b0);
      pin_go(1'b1);
      rd_chk("ctrl off", EPI_ADDR_CTRL, 8'h02);
      chk("off irq pulls", 3'h0, {cpu_irq, pull_up_en, pull_down_en});
   endtask : t_disabled
   // edge only mode for one polarity
   task automatic t_edge(input logic pol);
      logic [7:0] d;
      d = 8'h12 | {2'h0, pol, 5'h0};
      pin_go(~pol);
      wr(EPI_ADDR_CTRL, d);
      chk("pulls", {1'b0, pol, ~pol}, {1'b0, pull_down_en, pull_up_en});
      rd_chk("idle", EPI_ADDR_CTRL, d);
      rd_chk("pins idle", EPI_ADDR_PINS, {5'h0, 1'b0, pol, ~pol});
      @(posedge mclk);
      drv_val <= pol;
      repeat (2) @(posedge mclk);
      #1 chk("sync delay", 1'b0, cpu_irq);
      repeat (2) @(posedge mclk);
      #1 chk("cpu_irq", 1'b1, cpu_irq);
      rd_chk("flag", EPI_ADDR_CTRL, d | 8'h08);
      rd_chk("pins on", EPI_ADDR_PINS, {5'h0, 1'b1, pol, ~pol});
      wr(EPI_ADDR_CTRL, d | 8'h04);
      rd_chk("ack edge", EPI_ADDR_CTRL, d);
      pin_go(~pol);
      rd_chk("release", EPI_ADDR_CTRL, d);
      pin_rel(1'b0);
      rd_chk("pulled", EPI_ADDR_CTRL, d);
      pin_rel(1'b1);
      wr(EPI_ADDR_CTRL, 8'h00);
   endtask : t_edge
   // edge and level mode, high sense, polling, plus event status and mask
   task automatic t_level();
      pin_go(1'b0);
      wr(EPI_ADDR_CTRL, 8'h31);
      wr(EPI_ADDR_EVT, 8'h03);
      pin_go(1'b1);
      rd_chk("lvl flag", EPI_ADDR_CTRL, 8'h39);
      chk("poll", 1'b0, cpu_irq);
      wr(EPI_ADDR_CTRL, 8'h35);
      rd_chk("lvl hold", EPI_ADDR_CTRL, 8'h39);
      rd_chk("evt set", EPI_ADDR_EVT, 8'h03);
      chk("masked", 1'b0, sys_irq);
      wr(EPI_ADDR_MASK, 8'h01);
      chk("unmasked", 1'b1, sys_irq);
      wr(EPI_ADDR_EVT, 8'h01);
      chk("w1c", 1'b0, sys_irq);
      rd_chk("evt left", EPI_ADDR_EVT, 8'h02);
      wr(EPI_ADDR_MASK, 8'h02);
      chk("flag event", 1'b1, sys_irq);
      wr(EPI_ADDR_EVT, 8'h02);
      chk("flag w1c", 1'b0, sys_irq);
      rd_chk("evt clear", EPI_ADDR_EVT, 8'h00);
      pin_go(1'b0);
      wr(EPI_ADDR_CTRL, 8'h31);
      rd_chk("ack zero", EPI_ADDR_CTRL, 8'h39);
      wr(EPI_ADDR_CTRL, 8'h35);
      rd_chk("lvl clear", EPI_ADDR_CTRL, 8'h31);
      wr(EPI_ADDR_CTRL, 8'hC0);
      rd_chk("reserved", EPI_ADDR_CTRL, 8'h00);
   endtask : t_level
   // mid-run reset with a request pending restores every register
   task automatic t_midreset();
      wr(EPI_ADDR_CTRL, 8'h13);
      @(posedge mclk);
      #1 chk("pre reset irqs", 2'h3, {cpu_irq, sys_irq});
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      #1 chk("reset outs", 4'h0, {cpu_irq, sys_irq, pull_up_en, pull_down_en});
      t_reset();
   endtask : t_midreset
   initial begin
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_disabled();
      t_edge(1'b0);
      t_edge(1'b1);
      t_level();
      t_midreset();
      finish_test();
   end
endmodule : epi_detect_bench

// [tb/epi_pin_src.sv]
// behavioural board source for the external interrupt pin
`timescale 1ns/10ps
module epi_pin_src (
   input  wire logic mclk,
   input  wire logic drive_en,
   input  wire logic drive_val,
   input  wire logic pull_up_en,
   input  wire logic pull_down_en,
   output logic      irq_pin
);
   logic last_q = 1'b0;
   // released and unpulled pin wanders, so a stale level never passes
   always @(posedge mclk) begin
      last_q <= drive_en ? drive_val : ~last_q;
   end
   // driven level wins, then the pull resistor, then noise
   always_comb begin
      if (drive_en) irq_pin = drive_val;
      else if (pull_up_en) irq_pin = 1'b1;
      else if (pull_down_en) irq_pin = 1'b0;
      else irq_pin = ~last_q;
   end
endmodule : epi_pin_src

// [verilog/epi_detect.sv]
// external pin interrupt detect with ahb-lite register slave
`timescale 1ns/10ps
// Overview of operation
// [R1] polarity bit 5: 0 falling/low, 1 rising/high
// [R2] rising sense swaps pull-up for pull-down
// [R3] pin enable bit 4 gates interrupt function
// [R4] flag bit 3 reads one when pending
// [R5] writing one to bit 2 clears flag
// [R6] level mode: flag stays while pin asserted
// [R7] enable bit 1 drives request from flag
// [R8] mode bit 0: edge only or edge+level
// [R9] unimplemented bits read zero, writes ignored
// [R10] edge is deasserted-to-asserted transition only
// [R11] pin synchronised by two flip-flops first
// [R12] pin disabled: no flag, no request
module epi_detect
   import epi_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // pin side
   input  wire logic        irq_pin,
   output logic             pull_up_en,
   output logic             pull_down_en,
   // processor side
   output logic             cpu_irq,
   output logic             sys_irq
);

   // ****************************************
   // bus slave
   // ****************************************
   epi_phase_t phase_q, phase_d;
   logic [7:0] addr_q,  addr_d;
   logic       take;

   // zero wait state slave, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign take      = hsel && hready && htrans[1];

   // capture address phase
   always_comb begin
      phase_d = EPI_PH_IDLE;
      addr_d  = addr_q;
      if (take) begin
         phase_d = hwrite ? EPI_PH_WRITE : EPI_PH_READ;
         addr_d  = haddr;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         phase_q <= EPI_PH_IDLE;
         addr_q  <= 8'h00;
      end else begin
         phase_q <= phase_d;
         addr_q  <= addr_d;
      end
   end

   // write strobe per register, qualified by the data phase
   function automatic logic wr_hit(input epi_phase_t ph, input logic [7:0] a,
                                   input logic [7:0] target);
      wr_hit = (ph == EPI_PH_WRITE) && (a == target);
   endfunction : wr_hit

   // ****************************************
   // pin synchroniser and detector
   // ****************************************
   logic sync1_q, sync2_q, prev_q;
   logic asserted, prev_asserted, edge_seen;
   epi_cfg_t cfg_q, cfg_d;
   logic flag_q, flag_d;
   logic ack;

   // first stage feeds only the second; prev is taken from the second
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= irq_pin;                               // R11
         sync2_q <= sync1_q;                               // R11
         prev_q  <= sync2_q;
      end
   end

   // polarity maps the pin to an asserted level
   assign asserted      = cfg_q.pol ? sync2_q : ~sync2_q;      // R1
   assign prev_asserted = cfg_q.pol ? prev_q  : ~prev_q;
   // only deasserted-to-asserted counts; both sides use the live polarity, so no fake edge
   assign edge_seen     = asserted && !prev_asserted;          // R10

   assign ack = wr_hit(phase_q, addr_q, EPI_ADDR_CTRL) && hwdata[EPI_BIT_ACK];  // R5

   // control and flag next state; set beats acknowledge
   always_comb begin
      cfg_d  = cfg_q;
      flag_d = flag_q;
      if (wr_hit(phase_q, addr_q, EPI_ADDR_CTRL)) begin
         cfg_d.pol  = hwdata[EPI_BIT_POL];
         cfg_d.pe   = hwdata[EPI_BIT_PE];
         cfg_d.ie   = hwdata[EPI_BIT_IE];
         cfg_d.mode = hwdata[EPI_BIT_MODE];
      end
      if (ack) begin
         flag_d = 1'b0;                                   // R5
      end
      if (!cfg_q.pe) begin
         flag_d = 1'b0;                                   // R12
      end else if (edge_seen) begin
         flag_d = 1'b1;                                   // R8
      end else if (cfg_q.mode && asserted) begin
         flag_d = 1'b1;                                   // R6
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cfg_q  <= '{pol:  EPI_CTRL_RST[EPI_BIT_POL],
                     pe:   EPI_CTRL_RST[EPI_BIT_PE],
                     ie:   EPI_CTRL_RST[EPI_BIT_IE],
                     mode: EPI_CTRL_RST[EPI_BIT_MODE]};
         flag_q <= EPI_CTRL_RST[EPI_BIT_FLAG];
      end else begin
         cfg_q  <= cfg_d;
         flag_q <= flag_d;
      end
   end

   // request to processor, gated by enable and pin function
   assign cpu_irq = cfg_q.pe && cfg_q.ie && flag_q;       // R7 R12 R3

   // pull choice {down, up}: down for rising sense, up for falling, none when off
   function automatic logic [1:0] pull_sel(input epi_cfg_t c);
      pull_sel = {c.pe && c.pol, c.pe && !c.pol};
   endfunction : pull_sel

   // pull selection follows polarity while pin function is on
   assign {pull_down_en, pull_up_en} = pull_sel(cfg_q);   // R2

   // ****************************************
   // sticky event status and mask
   // ****************************************
   logic [EPI_EVT_W-1:0] evt_q, evt_d, mask_q, mask_d, evt_set;

   assign evt_set[EPI_EVT_EDGE] = cfg_q.pe && edge_seen;
   assign evt_set[EPI_EVT_FLAG] = flag_d && !flag_q;

   // write one clears, a same-cycle set wins
   always_comb begin
      evt_d  = evt_q;
      mask_d = mask_q;
      if (wr_hit(phase_q, addr_q, EPI_ADDR_EVT)) begin
         evt_d = evt_q & ~hwdata[EPI_EVT_W-1:0];
      end
      if (wr_hit(phase_q, addr_q, EPI_ADDR_MASK)) begin
         mask_d = hwdata[EPI_EVT_W-1:0];
      end
      evt_d = evt_d | evt_set;
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         evt_q  <= EPI_EVT_RST;
         mask_q <= EPI_MASK_RST;
      end else begin
         evt_q  <= evt_d;
         mask_q <= mask_d;
      end
   end

   assign sys_irq = |(evt_q & mask_q);

   // ****************************************
   // read data
   // ****************************************
   logic [31:0] rdata_q, rdata_d;

   // registered on the address phase so it stands in the data phase
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (take && !hwrite) begin
         case (haddr)
            EPI_ADDR_CTRL: begin
               // bits 7,6 and ack read zero
               rdata_d[EPI_BIT_POL]  = cfg_d.pol;         // R9
               rdata_d[EPI_BIT_PE]   = cfg_d.pe;
               rdata_d[EPI_BIT_FLAG] = flag_d;            // R4
               rdata_d[EPI_BIT_IE]   = cfg_d.ie;
               rdata_d[EPI_BIT_MODE] = cfg_d.mode;
            end
            EPI_ADDR_EVT:  rdata_d[EPI_EVT_W-1:0] = evt_d;
            EPI_ADDR_MASK: rdata_d[EPI_EVT_W-1:0] = mask_d;
            EPI_ADDR_PINS: rdata_d[2:0] = {cfg_d.pol ~^ sync2_q, pull_sel(cfg_d)};  // R2
            default:       rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign hrdata = rdata_q;

   // ****************************************
   // checks
   // ****************************************
   flag_off_a: assert property (@(posedge mclk) disable iff (!resetn) // R12
      !cfg_q.pe |=> !flag_q)
      else $error("flag set while pin disabled");

   req_follow_a: assert property (@(posedge mclk) disable iff (!resetn) // R7
      cpu_irq == (flag_q && cfg_q.ie && cfg_q.pe))
      else $error("request does not follow flag");

   edge_set_a: assert property (@(posedge mclk) disable iff (!resetn) // R10
      (cfg_q.pe && $stable(cfg_q.pol) && asserted && !prev_asserted) |=> flag_q)
      else $error("edge missed");

   sync_lat_a: assert property (@(posedge mclk) disable iff (!resetn) // R11
      $rose(sync2_q) |-> $past(irq_pin, 2))
      else $error("synchroniser latency wrong");

   level_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // R6
      (cfg_q.pe && cfg_q.mode && asserted) |=> flag_q)
      else $error("level mode flag cleared");

   ack_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // R5
      (ack && cfg_q.pe && !edge_seen && !(cfg_q.mode && asserted)) |=> !flag_q)
      else $error("acknowledge did not clear");

   pull_sel_a: assert property (@(posedge mclk) disable iff (!resetn) // R2
      !(pull_up_en && pull_down_en) && (cfg_q.pe == (pull_up_en || pull_down_en)))
      else $error("pull select wrong");

   rsv_zero_a: assert property (@(posedge mclk) disable iff (!resetn) // R9
      (take && !hwrite && haddr == EPI_ADDR_CTRL) |=> (hrdata[7:6] == 2'h0
         && !hrdata[EPI_BIT_ACK]))
      else $error("reserved bits not zero");

   no_edge_a: assert property (@(posedge mclk) disable iff (!resetn) // R8
      (!cfg_q.mode && !flag_q && !edge_seen && !ack) |=> !flag_q)
      else $error("edge mode set without edge");

   // event status, mask and read-back checks
   evt_edge_a: assert property (@(posedge mclk) disable iff (!resetn) // R10
      (cfg_q.pe && edge_seen) |=> evt_q[EPI_EVT_EDGE])
      else $error("edge event not recorded");

   evt_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
      (evt_q[EPI_EVT_FLAG] && !wr_hit(phase_q, addr_q, EPI_ADDR_EVT))
         |=> evt_q[EPI_EVT_FLAG])
      else $error("sticky event lost");

   evt_clr_a: assert property (@(posedge mclk) disable iff (!resetn)
      (wr_hit(phase_q, addr_q, EPI_ADDR_EVT) && hwdata[EPI_EVT_EDGE]
         && !(cfg_q.pe && edge_seen)) |=> !evt_q[EPI_EVT_EDGE])
      else $error("event not cleared by write one");

   mask_load_a: assert property (@(posedge mclk) disable iff (!resetn)
      wr_hit(phase_q, addr_q, EPI_ADDR_MASK) |=> (mask_q == $past(hwdata[EPI_EVT_W-1:0])))
      else $error("mask write lost");

   rise_set_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
      (cfg_q.pe && cfg_q.pol && $stable(cfg_q.pol) && $rose(sync2_q)) |=> flag_q)
      else $error("rising edge missed");

   fall_set_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
      (cfg_q.pe && !cfg_q.pol && $stable(cfg_q.pol) && $fell(sync2_q)) |=> flag_q)
      else $error("falling edge missed");

   flag_keep_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
      (flag_q && cfg_q.pe && !ack) |=> flag_q)
      else $error("flag dropped without acknowledge");

   flag_evt_a: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(flag_q) |-> evt_q[EPI_EVT_FLAG])
      else $error("flag rise not recorded");

   off_quiet_a: assert property (@(posedge mclk) disable iff (!resetn) // R12
      !cfg_q.pe |-> !(cpu_irq || pull_up_en || pull_down_en))
      else $error("disabled pin still active");

   rd_flag_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
      (take && !hwrite && haddr == EPI_ADDR_CTRL) |=> (hrdata[EPI_BIT_FLAG] == flag_q))
      else $error("flag read back wrong");

   pin_view_a: assert property (@(posedge mclk) disable iff (!resetn) // R2
      (take && !hwrite && haddr == EPI_ADDR_PINS)
         |=> (hrdata[1:0] == {pull_down_en, pull_up_en}))
      else $error("pull view read back wrong");
endmodule : epi_detect

// [verilog/epi_pkg.sv]
// package for the external pin interrupt detect block
package epi_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] EPI_ADDR_CTRL  = 8'h00;  // status and control
   localparam logic [7:0] EPI_ADDR_EVT   = 8'h04;  // sticky event status, write one to clear
   localparam logic [7:0] EPI_ADDR_MASK  = 8'h08;  // event mask
   localparam logic [7:0] EPI_ADDR_PINS  = 8'h0C;  // pull and pin state view

   // ****************************************
   // control register fields
   // ****************************************
   localparam int EPI_BIT_POL   = 5;
   localparam int EPI_BIT_PE    = 4;
   localparam int EPI_BIT_FLAG  = 3;
   localparam int EPI_BIT_ACK   = 2;
   localparam int EPI_BIT_IE    = 1;
   localparam int EPI_BIT_MODE  = 0;

   // ****************************************
   // event status fields
   // ****************************************
   localparam int EPI_EVT_EDGE  = 0;   // qualifying edge seen
   localparam int EPI_EVT_FLAG  = 1;   // request flag rose
   localparam int EPI_EVT_W     = 2;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0]          EPI_CTRL_RST = 8'h00;
   localparam logic [EPI_EVT_W-1:0] EPI_EVT_RST  = 2'h0;
   localparam logic [EPI_EVT_W-1:0] EPI_MASK_RST = 2'h0;

   // control fields carried together
   typedef struct packed {
      logic pol;
      logic pe;
      logic ie;
      logic mode;
   } epi_cfg_t;

   // bus data phase state
   typedef enum logic [1:0] {
      EPI_PH_IDLE,
      EPI_PH_WRITE,
      EPI_PH_READ
   } epi_phase_t;
endpackage : epi_pkg
